//--- rtl/core_irq_regs.svh
// Offsets, bit positions, reset values and timing counts of the mask block
`ifndef CORE_IRQ_REGS_SVH
`define CORE_IRQ_REGS_SVH

// Register byte offsets
`define CIRQ_OFF_MASK    8'h00
`define CIRQ_OFF_LATCH   8'h04
`define CIRQ_OFF_PEND    8'h08
`define CIRQ_OFF_CORE_TIMER_COUNT  8'h0C
`define CIRQ_OFF_PERIOD  8'h10
`define CIRQ_OFF_AUX     8'h14

// Source bit positions in mask, latch and request vectors
`define CIRQ_BIT_EMU     0
`define CIRQ_BIT_RST     1
`define CIRQ_BIT_RSVD    2
`define CIRQ_BIT_PARITY  3
`define CIRQ_BIT_OPCODE  4
`define CIRQ_BIT_CIRC7   5
`define CIRQ_BIT_INCOND  6
`define CIRQ_BIT_STACK   7
`define CIRQ_BIT_ADDR    8
`define CIRQ_BIT_FILT3   9
`define CIRQ_BIT_FILT4   10
`define CIRQ_BIT_TMRHI   11
`define CIRQ_BIT_TMRLO   12

// Auxiliary register fields
`define CIRQ_AUX_LOMASK  0
`define CIRQ_AUX_LOLATCH 1

// Reset values and fixed bit classes
`define CIRQ_MASK_RST    13'h0000
`define CIRQ_MASK_RO     13'h0003
`define CIRQ_MASK_RW     13'h1FF8
`define CIRQ_CORE_TIMER_COUNT_RST  32'h0000_0000
`define CIRQ_PERIOD_RST  32'h0000_0000

// Timer decrements once every this many clocks
`define CIRQ_TICK_DIV    4

`endif

//--- rtl/core_irq_pkg.sv
// Shared types of the core interrupt mask block
package core_irq_pkg;
    typedef logic [12:0] irq_vec_t;
    typedef logic [31:0] word_t;
endpackage : core_irq_pkg

//--- rtl/latch_if.sv
// Set, clear and flag bundle between the mask block and its latch bank
`timescale 1ns/10ps
interface latch_if #(parameter int W = 13);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;
    modport owner (input set, input clr, output flags);
    modport user  (output set, output clr, input flags);
endinterface : latch_if

//--- rtl/tick_divider.sv
// One-cycle enable pulse every DIV clocks
`timescale 1ns/10ps
module tick_divider #(
    parameter int DIV = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Enable out
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] count;

    generate
        if (DIV < 1) begin : g_bad_div
            $error("tick_divider: DIV must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == CW'(DIV - 1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : tick_divider

//--- rtl/irq_latch_bank.sv
// Sticky pending flags, set wins over write-one-to-clear
`timescale 1ns/10ps
module irq_latch_bank #(
    parameter int           W    = 13,
    parameter logic [W-1:0] IMPL = '1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Flag bundle
    latch_if.owner    lat
);
    generate
        if (W < 1) begin : g_bad_w
            $error("irq_latch_bank: W must be at least 1");
        end
    endgenerate

    // Unbuilt bits never set, so they always read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            lat.flags <= '0;
        end else begin
            lat.flags <= ((lat.flags & ~lat.clr) | lat.set) & IMPL;
        end
    end
endmodule : irq_latch_bank

//--- rtl/core_interrupt_mask_low.sv
// Lower interrupt mask, latch, core timer and APB slave of the core
//
// Summary of operation
// [R1] Mask bit 11 blocks the high-priority timer expiry when 0, passes it when 1; the code gates irq_request with it, not timer_expiry_high_irq.
// [R2] The high-priority timer request is raised when the timer count decrements to zero.
// [R3] One timer expiry requests both the high and the low timer interrupt, each behind its own mask; the timer pulse outputs here are not masked.
// [R4] Software should unmask only the timer expiry interrupt of the priority it wants.
// [R5] Mask bit 10 gates the fourth filter channel done request, present only when built.
// [R6] Mask bit 9 gates the third filter channel done request, present only when built.
// [R7] Mask bit 8 gates the illegal address space request.
// [R8] Mask bit 7 gates the sequencer stack overflow request.
// [R9] A stack overflow request is raised whenever any sequencer stack is full.
// [R10] Mask bit 6 gates the illegal input condition request.
// [R11] Mask bit 5 gates the circular buffer seven overflow request.
// [R12] Mask bit 4 gates the illegal opcode request.
// [R13] Mask bit 3 gates the level-one parity error request.
// [R14] Mask bit 1 is the read-only reset interrupt bit; reset is never masked.
// [R15] Mask bit 0 is the read-only emulator interrupt bit; emulator is never masked.
// [R16] The latch records a request while masked; it is taken once unmasked.
// [R17] Mask bit 2 is reserved: it reads zero and ignores writes.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "core_irq_regs.svh"
module core_interrupt_mask_low #(
    parameter int   NUM_STACKS  = 3,
    parameter bit   HAS_FILT3   = 1'b1,
    parameter bit   HAS_FILT4   = 1'b1,
    parameter int   TICK_DIV    = `CIRQ_TICK_DIV
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // APB slave
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Core event sources
    input  wire logic                  emulator_irq,
    input  wire logic                  reset_irq,
    input  wire logic                  l1_parity_error_irq,
    input  wire logic                  bad_opcode_irq,
    input  wire logic                  circ_buffer_seven_irq,
    input  wire logic                  bad_input_condition_irq,
    input  wire logic [NUM_STACKS-1:0] seq_stack_full,
    input  wire logic                  bad_address_irq,
    input  wire logic                  third_filter_done_irq,
    input  wire logic                  fourth_filter_done_irq,
    // To sequencer priority logic
    output core_irq_pkg::irq_vec_t     irq_request,
    output logic                       irq,
    output logic                       timer_expiry_high_irq,
    output logic                       timer_expiry_low_irq
);
    localparam core_irq_pkg::irq_vec_t FILT_OFF =
        core_irq_pkg::irq_vec_t'(
            ({12'h000, ~HAS_FILT3} << `CIRQ_BIT_FILT3) |
            ({12'h000, ~HAS_FILT4} << `CIRQ_BIT_FILT4));
    // Bits that exist in this build
    localparam core_irq_pkg::irq_vec_t IMPL =
        (`CIRQ_MASK_RW | `CIRQ_MASK_RO) & ~FILT_OFF;

    generate
        if (NUM_STACKS < 1) begin : g_bad_stacks
            $error("core_interrupt_mask_low: NUM_STACKS must be >= 1");
        end
    endgenerate

    core_irq_pkg::irq_vec_t mask_rw;
    core_irq_pkg::irq_vec_t mask_eff;
    core_irq_pkg::irq_vec_t next_set;
    core_irq_pkg::irq_vec_t next_clr;
    core_irq_pkg::word_t    core_timer_count;
    core_irq_pkg::word_t    timer_period;
    core_irq_pkg::word_t    rd_data;
    core_irq_pkg::word_t    wr_data;
    core_irq_pkg::word_t    mask_merged;
    logic                   addr_ok;
    logic                   access;
    logic                   xfer;
    logic                   wr_mask;
    logic                   wr_latch;
    logic                   wr_core_timer_count;
    logic                   wr_period;
    logic                   wr_aux;
    logic                   tick;
    logic                   expiry;

    latch_if #(.W(13)) lat ();

    tick_divider #(.DIV(TICK_DIV)) u_tick (
        .clk  (clk),
        .srst (srst),
        .tick (tick)
    );

    irq_latch_bank #(.W(13), .IMPL(IMPL)) u_latch (
        .clk  (clk),
        .srst (srst),
        .lat  (lat)
    );

    // APB: one wait state, so read data and error come from flops
    assign access = psel & penable;
    assign xfer   = access & pready;

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= access & ~pready;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= ~addr_ok;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Byte-lane merge of write data into the addressed register
    function automatic core_irq_pkg::word_t merge(
        input core_irq_pkg::word_t old_v,
        input core_irq_pkg::word_t new_v,
        input logic [3:0]          strb
    );
        core_irq_pkg::word_t r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        if (paddr == `CIRQ_OFF_MASK) begin
            rd_data = {20'h00000, mask_eff[11:0]};
        end else if (paddr == `CIRQ_OFF_LATCH) begin
            rd_data = {20'h00000, lat.flags[11:0]};
        end else if (paddr == `CIRQ_OFF_PEND) begin
            rd_data = {19'h00000, lat.flags & mask_eff};
        end else if (paddr == `CIRQ_OFF_CORE_TIMER_COUNT) begin
            rd_data = core_timer_count;
        end else if (paddr == `CIRQ_OFF_PERIOD) begin
            rd_data = timer_period;
        end else if (paddr == `CIRQ_OFF_AUX) begin
            rd_data = {30'h00000000, lat.flags[`CIRQ_BIT_TMRLO],
                       mask_rw[`CIRQ_BIT_TMRLO]};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Writes land only at the edge that completes the transfer
    assign wr_data   = merge(32'h0000_0000, pwdata, pstrb);
    assign mask_merged = merge({20'h00000, mask_rw[11:0]}, pwdata, pstrb);
    assign wr_mask   = xfer & pwrite & (paddr == `CIRQ_OFF_MASK);
    assign wr_latch  = xfer & pwrite & (paddr == `CIRQ_OFF_LATCH);
    assign wr_core_timer_count = xfer & pwrite & (paddr == `CIRQ_OFF_CORE_TIMER_COUNT);
    assign wr_period = xfer & pwrite & (paddr == `CIRQ_OFF_PERIOD);
    assign wr_aux    = xfer & pwrite & (paddr == `CIRQ_OFF_AUX);

    // Mask register: read-only and reserved bits never store
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_rw <= `CIRQ_MASK_RST;
        end else if (wr_mask) begin
            mask_rw <= {mask_rw[12], mask_merged[11:0]} & `CIRQ_MASK_RW; // R17
        end else if (wr_aux && pstrb[0]) begin
            mask_rw[`CIRQ_BIT_TMRLO] <= pwdata[`CIRQ_AUX_LOMASK];
        end
    end

    // Reset and emulator always pass; absent filter bits stay zero
    assign mask_eff = ((mask_rw & `CIRQ_MASK_RW) | `CIRQ_MASK_RO)
                      & IMPL; // R14 R15 R5 R6

    // Core timer: a tick at count one expires and loads the period in place of zero
    always_ff @(posedge clk) begin
        if (srst) begin
            core_timer_count <= `CIRQ_CORE_TIMER_COUNT_RST;
        end else if (wr_core_timer_count) begin
            core_timer_count <= merge(core_timer_count, pwdata, pstrb);
        end else if (expiry) begin
            core_timer_count <= timer_period;
        end else if (tick && core_timer_count != 32'h0000_0000) begin
            core_timer_count <= core_timer_count - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_period <= `CIRQ_PERIOD_RST;
        end else if (wr_period) begin
            timer_period <= merge(timer_period, pwdata, pstrb);
        end
    end

    assign expiry = tick & ~wr_core_timer_count &
                    (core_timer_count == 32'h0000_0001); // R2

    // Event sources into the latch; set wins over a same-cycle clear
    always_comb begin
        next_set = '0;
        next_set[`CIRQ_BIT_EMU]    = emulator_irq;
        next_set[`CIRQ_BIT_RST]    = reset_irq;
        next_set[`CIRQ_BIT_PARITY] = l1_parity_error_irq;      // R13
        next_set[`CIRQ_BIT_OPCODE] = bad_opcode_irq;           // R12
        next_set[`CIRQ_BIT_CIRC7]  = circ_buffer_seven_irq;    // R11
        next_set[`CIRQ_BIT_INCOND] = bad_input_condition_irq;  // R10
        next_set[`CIRQ_BIT_STACK]  = |seq_stack_full;          // R9
        next_set[`CIRQ_BIT_ADDR]   = bad_address_irq;          // R7
        next_set[`CIRQ_BIT_FILT3]  = third_filter_done_irq;    // R6
        next_set[`CIRQ_BIT_FILT4]  = fourth_filter_done_irq;   // R5
        next_set[`CIRQ_BIT_TMRHI]  = expiry;                   // R3
        next_set[`CIRQ_BIT_TMRLO]  = expiry;                   // R3
    end

    always_comb begin
        next_clr = '0;
        if (wr_latch) begin
            next_clr[11:0] = wr_data[11:0];
        end
        if (wr_aux) begin
            next_clr[`CIRQ_BIT_TMRLO] = wr_data[`CIRQ_AUX_LOLATCH];
        end
    end

    // Latched even while masked, so nothing is lost
    assign lat.set = next_set; // R16
    assign lat.clr = next_clr;

    // Requests to the sequencer: latch gated by mask
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_request <= '0;
            irq         <= 1'b0;
        end else begin
            irq_request <= lat.flags & mask_eff; // R1 R7 R8 R16
            irq         <= |(lat.flags & mask_eff);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_expiry_high_irq <= 1'b0;
            timer_expiry_low_irq  <= 1'b0;
        end else begin
            timer_expiry_high_irq <= expiry; // R3
            timer_expiry_low_irq  <= expiry; // R3
        end
    end

    // Checks
    a_timer_high_gate: assert property ( // R1
        @(posedge clk) disable iff (srst)
        !mask_rw[`CIRQ_BIT_TMRHI] |=> !irq_request[`CIRQ_BIT_TMRHI])
        else $error("timer high request passed while masked");

    a_timer_zero_event: assert property ( // R2
        @(posedge clk) disable iff (srst)
        (tick && !wr_core_timer_count && core_timer_count == 32'h0000_0001)
        |=> lat.flags[`CIRQ_BIT_TMRHI])
        else $error("timer reached zero without latching");

    a_timer_both_pulses: assert property ( // R3
        @(posedge clk) disable iff (srst)
        expiry |=> timer_expiry_high_irq && timer_expiry_low_irq
                   && lat.flags[`CIRQ_BIT_TMRLO])
        else $error("timer expiry did not raise both requests");

    a_filter_absent: assert property ( // R5
        @(posedge clk) disable iff (srst)
        !HAS_FILT4 |-> !lat.flags[`CIRQ_BIT_FILT4]
                       && !mask_eff[`CIRQ_BIT_FILT4])
        else $error("absent fourth filter bit is live");

    a_stack_any_full: assert property ( // R9
        @(posedge clk) disable iff (srst)
        (|seq_stack_full) |=> ##1 irq_request[`CIRQ_BIT_STACK]
                               == $past(mask_eff[`CIRQ_BIT_STACK]))
        else $error("stack full not latched into request");

    a_stack_gate: assert property ( // R8
        @(posedge clk) disable iff (srst)
        irq_request[`CIRQ_BIT_STACK] |-> $past(mask_rw[`CIRQ_BIT_STACK]))
        else $error("stack request passed while masked");

    a_reset_unmasked: assert property ( // R14
        @(posedge clk) disable iff (srst)
        reset_irq |=> ##1 irq_request[`CIRQ_BIT_RST] && irq)
        else $error("reset interrupt was masked");

    a_emu_unmasked: assert property ( // R15
        @(posedge clk) disable iff (srst)
        emulator_irq |=> ##1 irq_request[`CIRQ_BIT_EMU] && irq)
        else $error("emulator interrupt was masked");

    a_latch_while_masked: assert property ( // R16
        @(posedge clk) disable iff (srst)
        (bad_opcode_irq && !mask_rw[`CIRQ_BIT_OPCODE])
        |=> lat.flags[`CIRQ_BIT_OPCODE])
        else $error("masked event was not latched");

    a_taken_on_unmask: assert property ( // R16
        @(posedge clk) disable iff (srst)
        (lat.flags[`CIRQ_BIT_OPCODE] && !next_clr[`CIRQ_BIT_OPCODE]
         && $rose(mask_rw[`CIRQ_BIT_OPCODE])) |=> irq)
        else $error("latched event not taken after unmask");

    a_reserved_read: assert property ( // R17
        @(posedge clk) disable iff (srst)
        (xfer && !pwrite && paddr == `CIRQ_OFF_MASK)
        |-> prdata[2:0] == 3'h3)
        else $error("mask read shows wrong fixed bits");

    a_set_wins_clear: assert property ( // R11
        @(posedge clk) disable iff (srst)
        (circ_buffer_seven_irq && next_clr[`CIRQ_BIT_CIRC7])
        |=> lat.flags[`CIRQ_BIT_CIRC7])
        else $error("clear beat a same-cycle event");

    a_apb_wait_one: assert property (
        @(posedge clk) disable iff (srst)
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("APB answer not after one wait state");

    c_timer_expiry: cover property (
        @(posedge clk) disable iff (srst) expiry);
    c_masked_then_taken: cover property (
        @(posedge clk) disable iff (srst)
        !irq ##1 lat.flags[`CIRQ_BIT_PARITY] ##[1:20] irq);
    c_w1c_clear: cover property (
        @(posedge clk) disable iff (srst)
        lat.flags[`CIRQ_BIT_ADDR] && next_clr[`CIRQ_BIT_ADDR]);
    c_bad_address: cover property (
        @(posedge clk) disable iff (srst) xfer && pslverr);
endmodule : core_interrupt_mask_low

//--- testbench/irq_source_model.sv
// Behavioural core event sources feeding the mask block
`timescale 1ns/10ps
`include "core_irq_regs.svh"
module irq_source_model #(
    parameter int NUM_STACKS = 3
) (
    // Clock and command from the bench
    input  wire logic                  clk,
    input  wire logic [12:0]           fire,
    input  wire logic [1:0]            stack_sel,
    // Event lines
    output logic                       emulator_irq,
    output logic                       reset_irq,
    output logic                       l1_parity_error_irq,
    output logic                       bad_opcode_irq,
    output logic                       circ_buffer_seven_irq,
    output logic                       bad_input_condition_irq,
    output logic [NUM_STACKS-1:0]      seq_stack_full,
    output logic                       bad_address_irq,
    output logic                       third_filter_done_irq,
    output logic                       fourth_filter_done_irq
);
    // Quiet lines before the first edge, so nothing latches at time zero
    initial begin
        {emulator_irq, reset_irq, l1_parity_error_irq, bad_opcode_irq} = '0;
        {circ_buffer_seven_irq, bad_input_condition_irq} = '0;
        {bad_address_irq, third_filter_done_irq} = '0;
        fourth_filter_done_irq = 1'b0;
        seq_stack_full = '0;
    end

    // One registered single-cycle pulse per commanded source
    always @(posedge clk) begin
        emulator_irq            <= fire[`CIRQ_BIT_EMU];
        reset_irq               <= fire[`CIRQ_BIT_RST];
        l1_parity_error_irq     <= fire[`CIRQ_BIT_PARITY];
        bad_opcode_irq          <= fire[`CIRQ_BIT_OPCODE];
        circ_buffer_seven_irq   <= fire[`CIRQ_BIT_CIRC7];
        bad_input_condition_irq <= fire[`CIRQ_BIT_INCOND];
        bad_address_irq         <= fire[`CIRQ_BIT_ADDR];
        third_filter_done_irq   <= fire[`CIRQ_BIT_FILT3];
        fourth_filter_done_irq  <= fire[`CIRQ_BIT_FILT4];
        seq_stack_full          <= '0;
        // Any one of the stacks going full stands for an overflow
        if (fire[`CIRQ_BIT_STACK])
            seq_stack_full[stack_sel] <= 1'b1;
    end
endmodule : irq_source_model

//--- testbench/core_interrupt_mask_low_tb_top.sv
// Self-checking bench for the lower interrupt mask block
`timescale 1ns/10ps
`include "core_irq_regs.svh"
module core_interrupt_mask_low_tb_top;
    typedef struct {
        int                     src;
        core_irq_pkg::word_t    mask;
        core_irq_pkg::irq_vec_t req;
    } row_t;

    logic                   clk = 1'b0;
    logic                   srst = 1'b1;
    logic [7:0]             paddr = 8'h00;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [31:0]            pwdata = 32'h0000_0000;
    logic [3:0]             pstrb = 4'hF;
    logic [31:0]            prdata;
    logic                   pready, pslverr, irq;
    logic                   timer_expiry_high_irq, timer_expiry_low_irq;
    logic [12:0]            fire = 13'h0000;
    logic [1:0]             stack_sel = 2'h0;
    logic                   emulator_irq, reset_irq, l1_parity_error_irq;
    logic                   bad_opcode_irq, circ_buffer_seven_irq;
    logic                   bad_input_condition_irq, bad_address_irq;
    logic                   third_filter_done_irq, fourth_filter_done_irq;
    logic [2:0]             seq_stack_full;
    core_irq_pkg::irq_vec_t irq_request;
    core_irq_pkg::word_t    rd;
    logic                   err;
    int                     failures = 0;
    int                     num_checks = 0;

    row_t rows [15] = '{
        '{0,  32'h0000_0000, 13'h0001},
        '{1,  32'h0000_0000, 13'h0002},
        '{3,  32'h0000_0008, 13'h0008},
        '{3,  32'h0000_0FF7, 13'h0000},
        '{4,  32'h0000_0010, 13'h0010},
        '{5,  32'hFFFF_FFFF, 13'h0020},
        '{6,  32'h0000_0FBF, 13'h0000},
        '{6,  32'h0000_0040, 13'h0040},
        '{7,  32'h0000_0080, 13'h0080},
        '{7,  32'h0000_0F7F, 13'h0000},
        '{8,  32'h0000_0100, 13'h0100},
        '{8,  32'h0000_0EFF, 13'h0000},
        '{9,  32'h0000_0200, 13'h0200},
        '{10, 32'h0000_0BFF, 13'h0000},
        '{10, 32'h0000_0400, 13'h0400}
    };

    always #2 clk = ~clk;

    irq_source_model #(.NUM_STACKS(3)) irq_source_model_inst (
        .clk, .fire, .stack_sel, .emulator_irq, .reset_irq,
        .l1_parity_error_irq, .bad_opcode_irq, .circ_buffer_seven_irq,
        .bad_input_condition_irq, .seq_stack_full, .bad_address_irq,
        .third_filter_done_irq, .fourth_filter_done_irq
    );

    // Short tick divider keeps the timer scenario brief
    core_interrupt_mask_low #(.NUM_STACKS(3), .TICK_DIV(2))
        core_interrupt_mask_low_inst (
        .clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .emulator_irq, .reset_irq,
        .l1_parity_error_irq, .bad_opcode_irq, .circ_buffer_seven_irq,
        .bad_input_condition_irq, .seq_stack_full, .bad_address_irq,
        .third_filter_done_irq, .fourth_filter_done_irq, .irq_request,
        .irq, .timer_expiry_high_irq, .timer_expiry_low_irq
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic miss(input string what);
        failures++;
        $display("unexpected at %0t: %s", $time, what);
    endtask : miss

    task automatic chk_word(input core_irq_pkg::word_t got,
                            input core_irq_pkg::word_t exp, input string s);
        num_checks++;
        if (got !== exp)
            miss($sformatf("%s got %h exp %h", s, got, exp));
    endtask : chk_word

    task automatic chk_vec(input core_irq_pkg::irq_vec_t exp, input string s);
        num_checks++;
        if (irq_request !== exp)
            miss($sformatf("%s got %h exp %h", s, irq_request, exp));
    endtask : chk_vec

    task automatic chk_bit(input logic got, input logic exp, input string s);
        num_checks++;
        if (got !== exp)
            miss($sformatf("%s got %b", s, got));
    endtask : chk_bit

    // Full APB transfer; waits on pready rather than a fixed latency
    task automatic apb(input logic wr, input logic [7:0] a,
                       input core_irq_pkg::word_t d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16) begin
            miss("bus timeout");
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Must start at a clock edge
    task automatic pulse(input int src);
        fire <= 13'(13'h0001 << src);
        @(posedge clk);
        fire <= 13'h0000;
    endtask : pulse

    initial begin
        int i;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        tick(1);
        chk_bit(irq, 1'b0, "irq after reset");
        chk_vec(13'h0000, "request after reset");
        apb(1'b0, `CIRQ_OFF_MASK, 32'h0000_0000);
        chk_word(rd, 32'h0000_0003, "mask reset");
        apb(1'b0, `CIRQ_OFF_LATCH, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000, "latch reset");
        $display("test reset done");

        for (i = 0; i < 15; i++) begin
            stack_sel <= 2'(i % 3);
            apb(1'b1, `CIRQ_OFF_MASK, rows[i].mask);
            apb(1'b0, `CIRQ_OFF_MASK, 32'h0000_0000);
            chk_bit(err, 1'b0, "mapped error");
            chk_word(rd, (rows[i].mask & 32'h0000_0FF8) | 32'h0000_0003,
                     "mask readback");
            pulse(rows[i].src);
            tick(4);
            chk_vec(rows[i].req, "row request");
            chk_bit(irq, |rows[i].req, "row irq");
            apb(1'b0, `CIRQ_OFF_LATCH, 32'h0000_0000);
            chk_word(rd, 32'h0000_0001 << rows[i].src, "row latch");
            apb(1'b0, `CIRQ_OFF_PEND, 32'h0000_0000);
            chk_word(rd, {19'h00000, rows[i].req}, "row pending");
            apb(1'b1, `CIRQ_OFF_LATCH, 32'h0000_0FFF);
            apb(1'b0, `CIRQ_OFF_LATCH, 32'h0000_0000);
            chk_word(rd, 32'h0000_0000, "latch cleared");
        end
        $display("test table done");

        // Unmapped place: error answer, no data
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        chk_bit(err, 1'b1, "unmapped write error");
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk_bit(err, 1'b1, "unmapped read error");
        chk_word(rd, 32'h0000_0000, "unmapped read data");
        $display("test unmapped done");

        // Masked event stays latched and is taken once unmasked
        apb(1'b1, `CIRQ_OFF_MASK, 32'h0000_0000);
        pulse(`CIRQ_BIT_OPCODE);
        tick(4);
        chk_vec(13'h0000, "masked request");
        chk_bit(irq, 1'b0, "masked irq");
        apb(1'b1, `CIRQ_OFF_MASK, 32'h0000_0010);
        tick(2);
        chk_vec(13'h0010, "late unmask request");
        chk_bit(irq, 1'b1, "late unmask irq");
        apb(1'b1, `CIRQ_OFF_LATCH, 32'h0000_0FFF);
        $display("test latch while masked done");

        // Software first takes only the high timer with the low masked, then unmasks the low and masks the high
        apb(1'b1, `CIRQ_OFF_MASK, 32'h0000_0800);
        apb(1'b1, `CIRQ_OFF_AUX, 32'h0000_0000);
        apb(1'b1, `CIRQ_OFF_PERIOD, 32'h0000_0000);
        apb(1'b1, `CIRQ_OFF_CORE_TIMER_COUNT, 32'h0000_0003);
        for (i = 0; i < 64; i++) begin
            tick(1);
            if (timer_expiry_high_irq === 1'b1)
                break;
        end
        chk_bit(timer_expiry_high_irq, 1'b1, "high timer pulse");
        if (i == 64)
            tally_and_finish();
        chk_bit(timer_expiry_low_irq, 1'b1, "low timer pulse");
        tick(2);
        chk_vec(13'h0800, "high timer only");
        apb(1'b0, `CIRQ_OFF_AUX, 32'h0000_0000);
        chk_word(rd, 32'h0000_0002, "low timer latched");
        apb(1'b1, `CIRQ_OFF_AUX, 32'h0000_0001);
        tick(2);
        chk_vec(13'h1800, "both timers");
        apb(1'b1, `CIRQ_OFF_MASK, 32'h0000_0000);
        tick(2);
        chk_vec(13'h1000, "high timer masked");
        apb(1'b1, `CIRQ_OFF_AUX, 32'h0000_0003);
        apb(1'b1, `CIRQ_OFF_LATCH, 32'h0000_0800);
        tick(2);
        chk_bit(irq, 1'b0, "timer cleared");
        $display("test timer done");
        tally_and_finish();
    end
endmodule : core_interrupt_mask_low_tb_top
